// >>> core/sram_if_map.vh
// Constants of the asynchronous 512K x 8 static RAM and its controller.
// Assumes a 100 MHz system clock; cycle counts derive from ns figures.
`ifndef SRAM_IF_MAP_VH
`define SRAM_IF_MAP_VH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define SRAM_INDEX_W 19
`define SRAM_DATA_W 8
`define SRAM_WORDS 524288

// ----------------------------------------------------------------------
// Timing in ns and in cycles
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define INDEX_TO_DATA_DELAY_NS 70
`define SELECT_TO_DATA_DELAY_NS 70
`define DRIVE_ENABLE_TO_DATA_DELAY_NS 35
`define DATA_HOLD_AFTER_INDEX_CHANGE_NS 10
`define INDEX_SETUP_TO_WRITE_END_NS 60
`define DATA_SETUP_TO_WRITE_END_NS 30
`define INDEX_HOLD_AFTER_WRITE_END_NS 0
`define DESELECT_TO_POWER_DOWN_NS 70
// Read data pass three synchroniser stages and one agreement stage.
`define SYNC_LAT_CYC 4
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC (`CYC_UP(`SELECT_TO_DATA_DELAY_NS) + `SYNC_LAT_CYC + 1)
`define WRITE_LOW_CYC (`CYC_UP(`INDEX_SETUP_TO_WRITE_END_NS) + 1)
`define DATA_SETUP_CYC (`CYC_UP(`DATA_SETUP_TO_WRITE_END_NS) + 1)
`define POWER_DOWN_CYC `CYC_UP(`DESELECT_TO_POWER_DOWN_NS)

`endif

// >>> core/pin_sync.v
// Three-stage synchroniser for bits arriving from pins.
// The output changes only once the second and third stages agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 8
)
(
  input wire clk_sys,
  input wire nrst,
  input wire clk_en,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      always @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          out_q <= 1'b0;
        end
        else if (clk_en)
        begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
            out_q <= s3_q;
        end
      end
      assign sync_out[i] = out_q;
    end
  endgenerate
endmodule

// >>> core/sram_host_ctrl.v
// Host controller that drives an asynchronous 512K x 8 static RAM.
// Assumes one request at a time; the memory sits on the pins below.
//
// Function
// - Host times data to terminating edge.
// - Host never drives while memory drives.
// - Index stable 60 ns before write end.
// - Write data 30 ns before write end.
// - Index may change right at write end.
// - Index valid no later than select fall.
`timescale 1ns/1ps
`include "sram_if_map.vh"
module sram_host_ctrl #(
  parameter INDEX_W = `SRAM_INDEX_W,
  parameter DATA_W = `SRAM_DATA_W
)
(
  input wire clk_sys,
  input wire nrst,
  input wire clk_en,
  input wire req_valid,
  output wire req_ready,
  input wire req_write,
  input wire [INDEX_W-1:0] req_index,
  input wire [DATA_W-1:0] req_wdata,
  output reg rsp_valid,
  output reg [DATA_W-1:0] rsp_rdata,
  output reg power_down,
  output reg [INDEX_W-1:0] word_index,
  output reg select_n,
  output reg drive_enable_n,
  output reg write_strobe_n,
  input wire [DATA_W-1:0] data_lines_in,
  output reg [DATA_W-1:0] data_lines_out,
  output reg data_lines_oe
);

  // --------------------------------------------------------------------
  // States and counts
  // --------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RD = 5'h02;
  localparam [4:0] ST_WR = 5'h04;
  localparam [4:0] ST_WEND = 5'h08;
  localparam [4:0] ST_RDONE = 5'h10;
  // The counts are cut to the 4-bit counters on purpose; all fit.
  localparam integer READ_CYC_I = `READ_WAIT_CYC;
  localparam integer WRITE_CYC_I = `WRITE_LOW_CYC;
  localparam integer SETUP_CYC_I = `DATA_SETUP_CYC;
  localparam integer PD_CYC_I = `POWER_DOWN_CYC;
  localparam [3:0] READ_CYC = READ_CYC_I[3:0];
  localparam [3:0] WRITE_CYC = WRITE_CYC_I[3:0];
  localparam [3:0] SETUP_CYC = SETUP_CYC_I[3:0];
  localparam [3:0] PD_CYC = PD_CYC_I[3:0];

  reg [4:0] state_q;
  reg [3:0] cnt_q;
  reg [3:0] pd_cnt_q;
  wire [DATA_W-1:0] data_sync;

  // --------------------------------------------------------------------
  // Read data synchroniser
  // --------------------------------------------------------------------
  // The read wait adds margin for the synchroniser's latency.
  pin_sync #(
    .WIDTH(DATA_W)
  )
  u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .pin_in(data_lines_in),
    .sync_out(data_sync)
  );

  assign req_ready = state_q[0];

  // --------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------
  // One access at a time; req_ready is simply the idle state bit.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DATA_W{1'b0}};
      word_index <= {INDEX_W{1'b0}};
      select_n <= 1'b1;
      drive_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      data_lines_out <= {DATA_W{1'b0}};
      data_lines_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      rsp_valid <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (req_valid)
          begin
            // Index goes out in the same edge as select falls.
            word_index <= req_index;
            select_n <= 1'b0;
            cnt_q <= 4'h0;
            if (req_write)
            begin
              write_strobe_n <= 1'b0;
              drive_enable_n <= 1'b1;
              data_lines_out <= req_wdata;
              data_lines_oe <= 1'b1;
              state_q <= ST_WR;
            end
            else
            begin
              write_strobe_n <= 1'b1;
              drive_enable_n <= 1'b0;
              data_lines_oe <= 1'b0;
              state_q <= ST_RD;
            end
          end
        end
        ST_RD:
        begin
          // Waiting the select delay covers index and enable delays.
          // The data lines pass three synchroniser stages and one agreement stage before the
          // capture, so the wait counts that latency on top.
          if (cnt_q == READ_CYC - 4'h1)
          begin
            rsp_rdata <= data_sync;
            state_q <= ST_RDONE;
          end
          else
            cnt_q <= cnt_q + 4'h1;
        end
        ST_RDONE:
        begin
          // Index is held until after deselect, so old data stays.
          // The read data register stands until the next read's capture, one cycle before that read ends.
          select_n <= 1'b1;
          drive_enable_n <= 1'b1;
          rsp_valid <= 1'b1;
          state_q <= ST_IDLE;
        end
        ST_WR:
        begin
          // Data was set up from the start, well beyond its setup.
          // Index and data stand unchanged while the strobe is low.
          if (cnt_q == WRITE_CYC - 4'h1 && cnt_q >= SETUP_CYC - 4'h1)
          begin
            // Both lines rise together; the strobe edge ends the write.
            write_strobe_n <= 1'b1;
            select_n <= 1'b1;
            state_q <= ST_WEND;
          end
          else
            cnt_q <= cnt_q + 4'h1;
        end
        ST_WEND:
        begin
          // Data held one cycle past the end, more than zero hold.
          data_lines_oe <= 1'b0;
          rsp_valid <= 1'b1;
          state_q <= ST_IDLE;
        end
        default:
        begin
          // An illegal state code parks every strobe high.
          state_q <= ST_IDLE;
          select_n <= 1'b1;
          write_strobe_n <= 1'b1;
          drive_enable_n <= 1'b1;
          data_lines_oe <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Power-down tracking
  // --------------------------------------------------------------------
  // Flags the memory as in standby once the deselect time has passed.
  // It is only an estimate, since the memory reports nothing back.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pd_cnt_q <= 4'h0;
      power_down <= 1'b1;
    end
    else if (clk_en)
    begin
      if (!select_n)
      begin
        pd_cnt_q <= 4'h0;
        power_down <= 1'b0;
      end
      else if (pd_cnt_q == PD_CYC - 4'h1)
        power_down <= 1'b1;
      else
        pd_cnt_q <= pd_cnt_q + 4'h1;
    end
  end

endmodule

// >>> verif/sram_model.sv
// Behavioural 512K x 8 static RAM standing on the controller's pins.
// Assumes host pin names; it also resolves the shared data wire.
`timescale 1ns/1ps
module sram_model #(
  parameter RD_DLY = 70
)
(
  input wire select_n,
  input wire drive_enable_n,
  input wire write_strobe_n,
  input wire [18:0] word_index,
  input wire [7:0] data_lines_out,
  input wire data_lines_oe,
  output wire [7:0] data_lines_in
);
  reg [7:0] mem [0:524287];
  reg [7:0] q_q = 8'h00;
  wire rd = !select_n && !drive_enable_n && write_strobe_n;
  wire wr = !select_n && !write_strobe_n;
  // Released lines show the inverse, so stale data never looks valid.
  assign data_lines_in = data_lines_oe ? data_lines_out
    : (rd ? q_q : ~q_q);
  always @(negedge wr)
    mem[word_index] <= data_lines_out;
  always @(rd or word_index)
  begin
    q_q <= #10 ~q_q;
    if (rd)
      q_q <= #RD_DLY mem[word_index];
  end
endmodule

// >>> verif/sram_host_asserts.sv
// Pin assertions for sram_host_ctrl.
// Assumes clk_en drops only while idle, so access edges are enabled.
`timescale 1ns/1ps
module sram_host_asserts
(
  input wire clk_sys,
  input wire nrst,
  input wire req_ready,
  input wire rsp_valid,
  input wire power_down,
  input wire [18:0] word_index,
  input wire select_n,
  input wire drive_enable_n,
  input wire write_strobe_n,
  input wire [7:0] data_lines_out,
  input wire data_lines_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_wr_low;
    (!write_strobe_n && $stable(word_index))[*6];
  endsequence
  sequence s_rd_low;
    (!select_n && !drive_enable_n)[*8];
  endsequence
  sequence s_rd_tail;
    (!select_n && !drive_enable_n)[*5];
  endsequence
  property p_wr_len;
    $fell(write_strobe_n) |-> ##1 s_wr_low ##1
      (write_strobe_n && select_n);
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write pulse wrong");
  property p_wr_data;
    !write_strobe_n |-> data_lines_oe ##1 $stable(data_lines_out);
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write data moved");
  property p_wr_hold;
    $rose(write_strobe_n) |-> data_lines_oe ##1 (!data_lines_oe && rsp_valid);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write end wrong");
  property p_no_fight;
    !drive_enable_n |-> !data_lines_oe && write_strobe_n;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("bus fight");
  property p_rd_len;
    $fell(drive_enable_n) |-> s_rd_low ##1 s_rd_tail ##1
      (select_n && drive_enable_n && rsp_valid && req_ready);
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read length wrong");
  property p_idx_hold;
    !select_n && !$fell(select_n) |-> $stable(word_index);
  endproperty
  a_idx_hold: assert property (p_idx_hold)
    else $error("index moved");
  property p_power;
    $rose(select_n) ##1 select_n[*7] |-> power_down;
  endproperty
  a_power: assert property (p_power)
    else $error("no standby");
  property p_power_early;
    $rose(select_n) ##1 select_n[*6] |-> !power_down;
  endproperty
  a_power_early: assert property (p_power_early)
    else $error("standby too early");
  property p_busy;
    $fell(req_ready) |-> (!req_ready && !rsp_valid)[*7];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy too short");
endmodule

// >>> verif/testbench.sv
// Self-checking bench: sram_host_ctrl driving the behavioural RAM.
// Assumes the fixed latencies of 8 (write) and 13 (read) cycles.
`timescale 1ns/1ps
module testbench;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg clk_en = 1'b1;
  reg req_valid = 1'b0;
  reg req_write = 1'b0;
  reg [18:0] req_index = 19'h00000;
  reg [7:0] req_wdata = 8'h00;
  wire req_ready, rsp_valid, power_down, select_n, drive_enable_n;
  wire write_strobe_n, data_lines_oe;
  wire [18:0] word_index;
  wire [7:0] rsp_rdata, data_lines_out, data_lines_in;
  integer failures = 0;
  integer total_checks = 0;
  integer cyc = 0;
  always #5 clk_sys = ~clk_sys;
  sram_host_ctrl dut (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req_write(req_write),
    .req_index(req_index),
    .req_wdata(req_wdata),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .power_down(power_down),
    .word_index(word_index),
    .select_n(select_n),
    .drive_enable_n(drive_enable_n),
    .write_strobe_n(write_strobe_n),
    .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe)
  );
  sram_model ram (
    .select_n(select_n),
    .drive_enable_n(drive_enable_n),
    .write_strobe_n(write_strobe_n),
    .word_index(word_index),
    .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe),
    .data_lines_in(data_lines_in)
  );
  task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("wrong value %0s exp %h seen %h", what, exp, seen);
    end
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      failures = failures + 1;
      wrap_up;
    end
  end
  // Called at a falling edge; returns in the response cycle, so the
  // next call is taken back to back.
  task acc(input w, input [18:0] i, input [7:0] d, output [7:0] q);
    integer n;
  begin
    req_valid = 1'b1;
    req_write = w;
    req_index = i;
    req_wdata = d;
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n = n + 1;
    end
    check(n, w ? 8 : 13, "latency");
    q = rsp_rdata;
  end
  endtask
  task t_edges;
    reg [7:0] q;
  begin
    acc(1, 19'h00000, 8'h5a, q);
    acc(1, 19'h7ffff, 8'ha5, q);
    acc(0, 19'h00000, 8'h00, q);
    check(q, 8'h5a, "low");
    acc(0, 19'h7ffff, 8'h00, q);
    check(q, 8'ha5, "top");
  end
  endtask
  task t_rewrite;
    reg [7:0] q;
  begin
    acc(1, 19'h12345, 8'h0f, q);
    acc(1, 19'h12345, 8'hf0, q);
    acc(0, 19'h12345, 8'h00, q);
    check(q, 8'hf0, "rewrite");
    check(power_down, 1'b0, "active");
    repeat (6) @(negedge clk_sys);
    check(power_down, 1'b0, "early");
    @(negedge clk_sys);
    check(power_down, 1'b1, "standby");
  end
  endtask
  // Drops the clock enable with a request waiting: nothing may move.
  task t_freeze;
    reg [7:0] q;
  begin
    clk_en = 1'b0;
    req_valid = 1'b1;
    req_write = 1'b0;
    req_index = 19'h7ffff;
    repeat (3) @(negedge clk_sys);
    check({select_n, req_ready, power_down}, 3'b111, "frozen");
    clk_en = 1'b1;
    acc(0, 19'h12345, 8'h00, q);
    check(q, 8'hf0, "thawed");
  end
  endtask
  initial
  begin
    repeat (12) @(negedge clk_sys);
    check({select_n, drive_enable_n, write_strobe_n, data_lines_oe,
      power_down, req_ready}, 6'b111011, "reset");
    nrst = 1'b1;
    t_edges;
    t_rewrite;
    t_freeze;
    wrap_up;
  end
endmodule
bind sram_host_ctrl sram_host_asserts chk (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .req_ready(req_ready),
  .rsp_valid(rsp_valid),
  .power_down(power_down),
  .word_index(word_index),
  .select_n(select_n),
  .drive_enable_n(drive_enable_n),
  .write_strobe_n(write_strobe_n),
  .data_lines_out(data_lines_out),
  .data_lines_oe(data_lines_oe)
);
